// [bench/ppic_chk.sv]
// checker on the capture block ports
// assumes a bind from the bench top file
`timescale 1ns/1ps
module ppic_chk #(parameter WDOG_SHORT = 200, parameter WDOG_LONG = 400) (
    input wire logic       clk,        // console clock
    input wire logic       rstn,       // active low reset
    input wire logic       pulse_in,   // probe pulse
    input wire logic       long_probe, // timeout select
    input wire logic       gate,       // counter gate
    input wire logic       pair_valid, // capture strobe
    input wire logic [3:0] pair_slot,  // slot index
    input wire logic [1:0] pair_class, // slot kind
    input wire logic       in_sync,    // pause seen
    input wire logic       frame_err   // frame dropped
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    int quiet_q;
    // quiet time on the wire; sync latency makes the window a few clocks wide
    always @(posedge clk or negedge rstn)
        if (!rstn) quiet_q <= 0;
        else quiet_q <= pulse_in ? 0 : quiet_q + 1;
    property p_fall; pair_valid |-> $fell(gate); endproperty
    a_fall: assert property (p_fall) else $error("capture without gate close");
    property p_one; pair_valid |=> !pair_valid; endproperty
    a_one: assert property (p_one) else $error("capture strobe too long");
    property p_open; $rose(gate) |-> in_sync; endproperty
    a_open: assert property (p_open) else $error("gate opened before pause");
    property p_slot; pair_valid |-> pair_slot <= 4'hE; endproperty
    a_slot: assert property (p_slot) else $error("slot out of range");
    property p_water; pair_valid && pair_slot == 4'h1 |-> pair_class == 2'h1; endproperty
    a_water: assert property (p_water) else $error("water slot class");
    property p_kind; pair_valid && pair_slot != 4'h1
        |-> pair_class == (pair_slot[0] ? 2'h2 : 2'h0); endproperty
    a_kind: assert property (p_kind) else $error("slot class wrong");
    property p_err; frame_err |=> !frame_err; endproperty
    a_err: assert property (p_err) else $error("error strobe too long");
    property p_wdog; $rose(in_sync) |-> quiet_q >= (long_probe ? WDOG_LONG : WDOG_SHORT)
        && quiet_q <= (long_probe ? WDOG_LONG : WDOG_SHORT) + 12; endproperty
    a_wdog: assert property (p_wdog) else $error("sync not at timeout");
endmodule // ppic_chk

// [bench/ppic_probe.sv]
// probe model: pulse pairs and pauses on the pulse line
// assumes the bench calls its tasks; the line idles low
`timescale 1ns/1ps
module ppic_probe (
    input  wire logic clk,      // console clock
    output logic      pulse_in  // high during a pulse
);
    initial pulse_in = 1'b0;
    // two clocks wide; the leading edge carries the timing
    task automatic pulse();
        @(posedge clk) pulse_in <= 1'b1;
        repeat (2) @(posedge clk);
        pulse_in <= 1'b0;
    endtask
    // start floats by gap, stop follows at spacing d
    task automatic pair(input int d, input int gap);
        repeat (gap) @(posedge clk);
        pulse();
        repeat (d - 3) @(posedge clk);
        pulse();
    endtask
    // one silent pause then n pairs
    task automatic frame(input int pause, input int n);
        repeat (pause) @(posedge clk);
        for (int k = 0; k < n; k++) pair(20 + 3 * k, 40 + k);
    endtask
endmodule // ppic_probe

// [bench/pulse_pair_interval_capture_test.sv]
// bench: probe model drives pulses, each task judges the captures
// assumes shortened watchdog and two frames per reading
`timescale 1ns/1ps
module pulse_pair_interval_capture_test;
    localparam WS = 200;
    localparam WL = 400;
    logic clk = 1'b0, rstn = 1'b0, long_probe = 1'b0;
    wire pulse_in, gate, pair_valid, in_sync, frame_err, reading_done;
    wire [18:0] pair_count;
    wire [3:0] pair_slot;
    wire [1:0] pair_class;
    wire [31:0] acc_prod, acc_water, acc_temp;
    int error_cnt = 0, compares = 0, npair = 0, nerr = 0, ndone = 0;
    logic [18:0] cnt_a [15];
    logic [5:0] kind_a [15];
    ppic_capture #(.WDOG_SHORT(WS), .WDOG_LONG(WL), .FRAMES(2)) uut (.clk(clk),
        .rstn(rstn), .pulse_in(pulse_in), .long_probe(long_probe), .gate(gate),
        .pair_valid(pair_valid), .pair_count(pair_count), .pair_slot(pair_slot),
        .pair_class(pair_class), .in_sync(in_sync), .frame_err(frame_err),
        .reading_done(reading_done), .acc_prod(acc_prod), .acc_water(acc_water),
        .acc_temp(acc_temp));
    ppic_probe probe (.clk(clk), .pulse_in(pulse_in));
    initial forever #12.5 clk = ~clk;
    // log each capture and strobe as it stands
    always @(posedge clk) begin
        if (pair_valid === 1'b1 && npair < 15) begin
            cnt_a[npair] = pair_count;
            kind_a[npair] = {pair_slot, pair_class};
            npair++;
        end
        nerr += (frame_err === 1'b1);
        ndone += (reading_done === 1'b1);
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_nosync();
        probe.pair(30, 20);
        probe.pair(30, 20);
        repeat (10) @(posedge clk);
        check("pairs", npair, 0);
        check("sync", in_sync, 0);
        check("gate", gate, 0);
        $display("nosync done");
    endtask
    // the gate opens a clock after the first edge, so a count is its spacing less one
    task automatic t_frame(input int f);
        int d;
        int ep = 0;
        int ew = 0;
        int et = 0;
        npair = 0;
        probe.frame(WS + 20, 15);
        repeat (10) @(posedge clk);
        check("pairs", npair, 15);
        for (int k = 0; k < 15; k++) begin
            d = 20 + 3 * k;
            check("count", cnt_a[k], d - 1);
            if (k == 1) ew += d - 1;
            else if (k[0]) ep += d - 1;
            else et += d - 1;
            check("kind", kind_a[k], {k[3:0], k == 1 ? 2'h1 : (k[0] ? 2'h2 : 2'h0)});
        end
        check("sync", in_sync, 0);
        check("done", ndone, f);
        if (f) begin
            check("product", acc_prod, 2 * ep);
            check("water", acc_water, 2 * ew);
            check("temp", acc_temp, 2 * et);
        end
        $display("frame done");
    endtask
    // long timeout: short pause ignored, then a cut frame is dropped
    task automatic t_abort();
        long_probe <= 1'b1;
        npair = 0;
        probe.frame(WS + 50, 3);
        repeat (10) @(posedge clk);
        check("pairs", npair, 0);
        check("sync", in_sync, 0);
        probe.frame(WL + 20, 5);
        probe.frame(WL + 20, 0);
        repeat (10) @(posedge clk);
        check("pairs", npair, 5);
        check("error", nerr, 1);
        $display("abort done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_nosync();
        t_frame(0);
        t_frame(1);
        t_abort();
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule // pulse_pair_interval_capture_test
bind ppic_capture ppic_chk #(.WDOG_SHORT(WDOG_SHORT), .WDOG_LONG(WDOG_LONG)) chk (.clk(clk),
    .rstn(rstn), .pulse_in(pulse_in), .long_probe(long_probe), .gate(gate),
    .pair_valid(pair_valid), .pair_slot(pair_slot), .pair_class(pair_class),
    .in_sync(in_sync), .frame_err(frame_err));

// [hdl/ppic_capture.v]
// pulse pair interval capture: console side logic for a level probe
// gate, interval counter, pause watchdog, slot tracking and per-reading sums
// assumes pulse_in is an asynchronous discriminator output, high while a pulse is seen
// assumes long_probe is a static setting from logic on the same clock
`timescale 1ns/1ps
`include "ppic_defines.vh"

// How it works
// - time events on pulse leading edge
// - gate opens first pulse, closes second
// - gate close tells host data ready
// - every pulse restarts the watchdog
// - watchdog expiry 7 or 14 ms
// - after expiry record fifteen pairs by slot
// - align only by watchdog timeout
// - counter wide enough for longest pair
// - clock rate sets count resolution
// - sort pairs, accumulate over frames
// - several frames form one reading
// - allow one extra frame to synchronise
module ppic_capture #(
    parameter CNT_W      = `PPIC_CNT_W,           // interval counter width
    parameter ACC_W      = 32,                    // accumulator width
    parameter WDOG_SHORT = `PPIC_WDOG_SHORT_CYC,  // timeout cycles, short probes
    parameter WDOG_LONG  = `PPIC_WDOG_LONG_CYC,   // timeout cycles, long probes
    parameter FRAMES     = `PPIC_DEF_FRAMES       // frames per reading
) (
    input  wire             clk,           // 40 MHz console clock
    input  wire             rstn,          // async active low reset
    input  wire             pulse_in,      // discriminated probe pulse, async
    input  wire             long_probe,    // selects the long watchdog timeout
    output reg              gate,          // high while interval counter runs
    output reg              pair_valid,    // one-cycle pulse: pair_count ready
    output reg  [CNT_W-1:0] pair_count,    // captured interval in clocks
    output reg  [3:0]       pair_slot,     // slot index 0..14 of captured pair
    output reg  [1:0]       pair_class,    // temp, water or product
    output reg              in_sync,       // a pause has been seen since the last full frame of fifteen pairs
    output reg              frame_err,     // one-cycle pulse: partial frame dropped
    output reg              reading_done,  // one-cycle pulse: accumulators valid
    output reg  [ACC_W-1:0] acc_prod,      // product sum over frames
    output reg  [ACC_W-1:0] acc_water,     // water sum over frames
    output reg  [ACC_W-1:0] acc_temp       // all temperature pairs summed
);

    localparam WD_W = 32;

    // both timeout limits held at the watchdog width so the compare is width matched
    localparam [WD_W-1:0] WD_SHORT_L = WDOG_SHORT;
    localparam [WD_W-1:0] WD_LONG_L  = WDOG_LONG;

    // class of a slot: slot 0 is reading 1 (even pair in the frame numbering)
    // slot 1 carries water, the other odd slots product, even slots temperature
    function [1:0] slot_class;
        input [3:0] s;
        begin
            if (s == `PPIC_WATER_SLOT)
                slot_class = `PPIC_CLASS_WATER;
            else if (s[0])
                slot_class = `PPIC_CLASS_PROD;
            else
                slot_class = `PPIC_CLASS_TEMP;
        end
    endfunction

    // synchroniser and edge detector stages
    reg              rst_m_q;   // reset release, first stage
    reg              rst_s_q;   // reset release, second stage
    reg              p_m_q;     // pulse sync, first stage
    reg              p_s_q;     // pulse sync, second stage
    reg              p_d_q;     // delayed copy for the edge detector
    // timers, slot index and running sums
    reg [WD_W-1:0]   wd_q;      // pulse silence counter
    reg [CNT_W-1:0]  cnt_q;     // interval counter
    reg [3:0]        slot_q;    // slot of the pair now being timed
    reg [7:0]        frm_q;     // frames summed so far
    reg [ACC_W-1:0]  sp_q;      // product running sum
    reg [ACC_W-1:0]  sw_q;      // water running sum
    reg [ACC_W-1:0]  st_q;      // temperature running sum
    // decoded events
    wire             rst_n  = rst_s_q;
    wire             edge_p = p_s_q & ~p_d_q;
    wire [WD_W-1:0]  wd_lim = long_probe ? WD_LONG_L : WD_SHORT_L;
    // greater or equal: after a long to short switch the count may already be past
    wire             expire = (wd_q >= wd_lim);
    wire [ACC_W-1:0] cnt_x  = {{(ACC_W-CNT_W){1'b0}}, cnt_q};

    // reset release synchroniser
    // everything below resets from the second stage, so release lands on one edge
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // pulse input synchroniser; the third stage feeds only the edge detector
    // a pulse narrower than one clock can slip between samples and be missed
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p_m_q <= 1'b0;
            p_s_q <= 1'b0;
            p_d_q <= 1'b0;
        end else begin
            p_m_q <= pulse_in;
            p_s_q <= p_m_q;
            p_d_q <= p_s_q;   // leading edge only; width of the pulse is ignored
        end
    end

    // watchdog: holds at the limit, so expire stays high for the rest of the silence
    // every synced leading edge restarts it, start and stop pulse alike
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            wd_q <= {WD_W{1'b0}};
        else if (edge_p)
            wd_q <= {WD_W{1'b0}};
        else if (!expire)
            wd_q <= wd_q + 1'b1;
    end

    // gate, interval counter, slot tracking and frame accumulation
    // slot_q tracks the pair being timed; pair_slot shows the one handed over
    // after fifteen pairs nothing is taken until the next pause, so a stray
    // pulse cannot shift the slot numbering of the next frame
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate         <= 1'b0;
            cnt_q        <= {CNT_W{1'b0}};
            pair_valid   <= 1'b0;
            pair_count   <= {CNT_W{1'b0}};
            pair_slot    <= 4'h0;
            slot_q       <= 4'h0;
            pair_class   <= `PPIC_CLASS_TEMP;
            in_sync      <= 1'b0;
            frame_err    <= 1'b0;
            reading_done <= 1'b0;
            acc_prod     <= {ACC_W{1'b0}};
            acc_water    <= {ACC_W{1'b0}};
            acc_temp     <= {ACC_W{1'b0}};
            frm_q        <= 8'h00;
            sp_q         <= {ACC_W{1'b0}};
            sw_q         <= {ACC_W{1'b0}};
            st_q         <= {ACC_W{1'b0}};
        end else begin
            pair_valid   <= 1'b0;
            frame_err    <= 1'b0;
            reading_done <= 1'b0;
            // counter free-runs while the gate is open; saturates rather than wraps
            // one count per clk period, so the clock rate sets the resolution
            if (gate && cnt_q != {CNT_W{1'b1}})
                cnt_q <= cnt_q + 1'b1;
            if (expire && wd_q != {WD_W{1'b0}} && !edge_p) begin
                // pause found: only sync source, slots are never timed
                // a pause inside a started frame drops the partial sums
                if (in_sync && (gate || slot_q != 4'h0)) begin
                    frame_err <= 1'b1;
                    sp_q  <= {ACC_W{1'b0}};
                    sw_q  <= {ACC_W{1'b0}};
                    st_q  <= {ACC_W{1'b0}};
                    frm_q <= 8'h00;
                end
                in_sync   <= 1'b1;
                gate      <= 1'b0;
                slot_q    <= 4'h0;
                cnt_q     <= {CNT_W{1'b0}};
            end else if (edge_p && in_sync) begin
                // first pulse of a pair opens the gate
                if (!gate) begin
                    gate  <= 1'b1;
                    cnt_q <= {CNT_W{1'b0}};
                // second pulse closes it and hands the count over with its slot
                end else if (slot_q < `PPIC_PAIRS_PER_FRAME) begin
                    gate       <= 1'b0;
                    pair_valid <= 1'b1;
                    pair_count <= cnt_q;
                    pair_slot  <= slot_q;
                    pair_class <= slot_class(slot_q);
                    case (slot_class(slot_q))
                        `PPIC_CLASS_PROD:  sp_q <= sp_q + cnt_x;
                        `PPIC_CLASS_WATER: sw_q <= sw_q + cnt_x;
                        default:           st_q <= st_q + cnt_x;
                    endcase
                    if (slot_q == `PPIC_PAIRS_PER_FRAME - 1) begin
                        // frame complete: stay out of capture until the next pause
                        slot_q    <= 4'h0;
                        in_sync   <= 1'b0;
                        if (frm_q == FRAMES[7:0] - 8'h01) begin
                            // full reading: hand the sums over and start again
                            reading_done <= 1'b1;
                            acc_prod  <= sp_q + ((slot_class(slot_q) ==
                                         `PPIC_CLASS_PROD) ? cnt_x : {ACC_W{1'b0}});
                            acc_water <= sw_q;
                            acc_temp  <= st_q + ((slot_class(slot_q) ==
                                         `PPIC_CLASS_TEMP) ? cnt_x : {ACC_W{1'b0}});
                            sp_q  <= {ACC_W{1'b0}};
                            sw_q  <= {ACC_W{1'b0}};
                            st_q  <= {ACC_W{1'b0}};
                            frm_q <= 8'h00;
                        end else begin
                            frm_q <= frm_q + 8'h01;
                        end
                    end else begin
                        slot_q <= slot_q + 4'h1;
                    end
                end
            end
        end
    end

endmodule // ppic_capture

// [hdl/ppic_defines.vh]
// constants for the pulse pair interval capture console block
// assumes a 40 MHz system clock; times are kept in their printed units
`ifndef PPIC_DEFINES_VH
`define PPIC_DEFINES_VH

`define PPIC_CLK_MHZ         40
`define PPIC_WDOG_SHORT_MS   7
`define PPIC_WDOG_LONG_MS    14
`define PPIC_WDOG_SHORT_CYC  (`PPIC_WDOG_SHORT_MS * 1000 * `PPIC_CLK_MHZ)
`define PPIC_WDOG_LONG_CYC   (`PPIC_WDOG_LONG_MS * 1000 * `PPIC_CLK_MHZ)
`define PPIC_PAIRS_PER_FRAME 15
`define PPIC_CNT_W           19
`define PPIC_DEF_FRAMES      16
`define PPIC_WATER_SLOT      4'h1
`define PPIC_CLASS_TEMP      2'h0
`define PPIC_CLASS_WATER     2'h1
`define PPIC_CLASS_PROD      2'h2

`endif
